/* File: rtl/mlps_map.svh */
`ifndef MLPS_MAP_SVH
`define MLPS_MAP_SVH

// register byte offsets
`define MLPS_OFS_CTRL 8'h00
`define MLPS_OFS_STATUS 8'h04
`define MLPS_OFS_TIMER 8'h08

// ctrl fields
`define MLPS_CTRL_DRIVE_EN 0
`define MLPS_CTRL_DETECT_EN 1
`define MLPS_CTRL_RESET 2'h3

// status fields
`define MLPS_ST_LOCK 0
`define MLPS_ST_THERM 1
`define MLPS_ST_SPEED_LOW 2
`define MLPS_ST_CAUSE_LSB 4

// timing
`define MLPS_CLK_MHZ 20
`define MLPS_TICK_US 1000
`define MLPS_TICK_CYCLES (`MLPS_TICK_US * `MLPS_CLK_MHZ)
`define MLPS_LOCK_DETECT_MS 13'd500
`define MLPS_RETRY_MS 13'd5000

// speed command threshold, per mille of pwm period
`define MLPS_SPEED_PERMIL 26'd30
`define MLPS_PERMIL_FULL 26'd1000
`define MLPS_PWM_CNT_MAX 16'hFFFF

`endif

/* File: rtl/mlps_pkg.sv */
package mlps_pkg;

  typedef enum logic [1:0] {
    MLPS_ST_RUN  = 2'b01,
    MLPS_ST_LOCK = 2'b10
  } mlps_state_t;

  typedef enum logic [3:0] {
    MLPS_CAUSE_NONE    = 4'h0,
    MLPS_CAUSE_STANDBY = 4'h1,
    MLPS_CAUSE_SUPPLY_LOW_LOCKOUT    = 4'h2,
    MLPS_CAUSE_RETRY   = 4'h3,
    MLPS_CAUSE_HALL    = 4'h4,
    MLPS_CAUSE_SPEED   = 4'h5,
    MLPS_CAUSE_DIR     = 4'h6,
    MLPS_CAUSE_BRAKE   = 4'h7
  } mlps_cause_t;

endpackage

/* File: rtl/mlps_tick_gen.sv */
`timescale 1ns/10ps
`default_nettype none
`include "mlps_map.svh"
module mlps_tick_gen
  import mlps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MLPS_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // tick carrier
  mlps_tick_if.src tb
);

  logic [15:0] cnt_r;
  logic tick_r;
  wire logic wrap = (cnt_r == 16'(TICK_CYCLES - 1));

  // the divider restarts when stopped so each run starts with a full period
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= (!tb.run || wrap) ? 16'h0000 : cnt_r + 16'h0001;
      tick_r <= tb.run && wrap;
    end
  end

  assign tb.tick = tick_r;

endmodule
`default_nettype wire

/* File: rtl/mlps_tick_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mlps_tick_if;
  logic tick;
  logic run;
  modport src (output tick, input run);
  modport snk (input tick, output run);
endinterface
`default_nettype wire

/* File: rtl/mlps_top.sv */
// Local design decisions: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "mlps_map.svh"
module mlps_top
  import mlps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = `MLPS_TICK_CYCLES
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // motor sense and control pins
  input wire logic hall_diff_input,
  input wire logic restart_disable_pin,
  input wire logic standby_request,
  input wire logic supply_low_lockout,
  input wire logic speed_mode_pwm,
  input wire logic speed_command_input,
  input wire logic speed_below_linear,
  input wire logic direction_select,
  input wire logic brake_request,
  input wire logic temp_above_trip,
  input wire logic temp_below_release,
  // drive from the waveform generator
  input wire logic [2:0] drive_hi,
  input wire logic [2:0] drive_lo,
  // bridge gates and flags
  output logic [2:0] gate_hi,
  output logic [2:0] gate_lo,
  output logic lock_active
);

  ////////////////////////////////////////////////////////////////////////////
  // time base

  mlps_tick_if tb ();

  mlps_tick_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .tb(tb)
  );

  assign tb.run = 1'b1;

  function automatic logic [12:0] sat_inc(input logic [12:0] v, input logic [12:0] lim);
    sat_inc = (v >= lim) ? lim : v + 13'd1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave

  logic [1:0] ctrl_r;
  logic wr_pend_r;
  logic rd_pend_r;
  logic [7:0] addr_r;
  logic hreadyout_r;
  logic [31:0] hrdata_r;
  logic [31:0] status_w;
  logic [12:0] retry_cnt_r;
  logic [31:0] rd_mux;

  wire logic bus_take = hsel && hready && htrans[1];
  wire logic sel_ctrl = (addr_r == `MLPS_OFS_CTRL);
  wire logic sel_status = (addr_r == `MLPS_OFS_STATUS);
  wire logic sel_timer = (addr_r == `MLPS_OFS_TIMER);

  assign rd_mux = sel_ctrl ? {30'h00000000, ctrl_r} :
                  sel_status ? status_w :
                  sel_timer ? {19'h00000, retry_cnt_r} : 32'h00000000;

  // reads take one wait state so a read right after a write sees the new value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      addr_r <= 8'h00;
      hreadyout_r <= 1'b1;
      hrdata_r <= 32'h00000000;
    end else begin
      wr_pend_r <= bus_take && hwrite;
      rd_pend_r <= bus_take && !hwrite;
      if (bus_take) begin
        addr_r <= {haddr[7:2], 2'b00};
      end
      hreadyout_r <= !(bus_take && !hwrite);
      if (rd_pend_r) begin
        hrdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `MLPS_CTRL_RESET;
    end else if (wr_pend_r && sel_ctrl) begin
      ctrl_r <= hwdata[1:0];
    end
  end

  assign hreadyout = hreadyout_r;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  wire logic drive_en = ctrl_r[`MLPS_CTRL_DRIVE_EN];
  wire logic detect_en = ctrl_r[`MLPS_CTRL_DETECT_EN];

  ////////////////////////////////////////////////////////////////////////////
  // input edge detection

  logic hall_q_r;
  logic dir_q_r;
  logic spd_q_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hall_q_r <= 1'b0;
      dir_q_r <= 1'b0;
      spd_q_r <= 1'b0;
    end else begin
      hall_q_r <= hall_diff_input;
      dir_q_r <= direction_select;
      spd_q_r <= speed_command_input;
    end
  end

  wire logic hall_fall = hall_q_r && !hall_diff_input;
  wire logic dir_change = (dir_q_r != direction_select);
  wire logic spd_rise = !spd_q_r && speed_command_input;

  ////////////////////////////////////////////////////////////////////////////
  // speed command duty measurement

  logic [15:0] per_cnt_r;
  logic [15:0] high_cnt_r;
  logic pwm_low_r;
  logic [25:0] high_scaled;
  logic [25:0] per_scaled;

  assign high_scaled = 26'(high_cnt_r) * `MLPS_PERMIL_FULL;
  assign per_scaled = 26'(per_cnt_r) * `MLPS_SPEED_PERMIL;

  wire logic per_full = (per_cnt_r == `MLPS_PWM_CNT_MAX);

  // a pin stuck low never shows a rising edge, so the saturated period
  // counter stands in as a zero duty reading
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_cnt_r <= 16'h0000;
      high_cnt_r <= 16'h0000;
      pwm_low_r <= 1'b0;
    end else if (spd_rise) begin
      pwm_low_r <= (high_scaled < per_scaled);
      per_cnt_r <= 16'h0001;
      high_cnt_r <= 16'h0001;
    end else begin
      if (!per_full) begin
        per_cnt_r <= per_cnt_r + 16'h0001;
      end
      if (speed_command_input && !per_full) begin
        high_cnt_r <= high_cnt_r + 16'h0001;
      end
      if (per_full) begin
        pwm_low_r <= !speed_command_input;
      end
    end
  end

  wire logic speed_low = speed_mode_pwm ? pwm_low_r : speed_below_linear;

  ////////////////////////////////////////////////////////////////////////////
  // lock protection state machine

  mlps_state_t state_r;
  mlps_state_t state_nxt;
  mlps_cause_t cause_r;
  mlps_cause_t cause_nxt;
  logic [12:0] hall_ms_r;
  logic lock_active_r;

  wire logic hard_release = standby_request || supply_low_lockout;
  wire logic soft_ok = !restart_disable_pin;
  wire logic retry_due = (retry_cnt_r >= `MLPS_RETRY_MS);
  wire logic interval_due = (hall_ms_r >= `MLPS_LOCK_DETECT_MS);
  wire logic engage = detect_en && drive_en && !hard_release && interval_due;

  always_comb begin
    state_nxt = state_r;
    cause_nxt = cause_r;
    unique case (state_r)
      MLPS_ST_RUN: begin
        if (engage) begin
          state_nxt = MLPS_ST_LOCK;
        end
      end
      MLPS_ST_LOCK: begin
        if (standby_request) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_STANDBY;
        end else if (supply_low_lockout) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_SUPPLY_LOW_LOCKOUT;
        end else if (soft_ok && retry_due) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_RETRY;
        end else if (soft_ok && hall_fall) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_HALL;
        end else if (soft_ok && speed_low) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_SPEED;
        end else if (soft_ok && dir_change) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_DIR;
        end else if (soft_ok && brake_request) begin
          state_nxt = MLPS_ST_RUN;
          cause_nxt = MLPS_CAUSE_BRAKE;
        end
      end
    endcase
  end

  wire logic releasing = (state_r == MLPS_ST_LOCK) && (state_nxt == MLPS_ST_RUN);
  wire logic locked = (state_r == MLPS_ST_LOCK);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= MLPS_ST_RUN;
      cause_r <= MLPS_CAUSE_NONE;
    end else begin
      state_r <= state_nxt;
      cause_r <= cause_nxt;
    end
  end

  // the interval restarts on every release so the motor gets a full
  // detection window to spin up again
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hall_ms_r <= 13'd0;
    end else if (hall_fall || locked || hard_release || !drive_en) begin
      hall_ms_r <= 13'd0;
    end else if (tb.tick) begin
      hall_ms_r <= sat_inc(hall_ms_r, `MLPS_LOCK_DETECT_MS);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      retry_cnt_r <= 13'd0;
    end else if (!locked || releasing) begin
      retry_cnt_r <= 13'd0;
    end else if (tb.tick) begin
      retry_cnt_r <= sat_inc(retry_cnt_r, `MLPS_RETRY_MS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thermal shutdown latch

  logic therm_off_r;

  // trip wins over release if the two indications ever overlap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      therm_off_r <= 1'b0;
    end else if (temp_above_trip) begin
      therm_off_r <= 1'b1;
    end else if (temp_below_release) begin
      therm_off_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bridge output override

  logic [2:0] gate_hi_r;
  logic [2:0] gate_lo_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gate_hi_r <= 3'h0;
      gate_lo_r <= 3'h0;
      lock_active_r <= 1'b0;
    end else begin
      lock_active_r <= (state_nxt == MLPS_ST_LOCK);
      if (therm_off_r || temp_above_trip || !drive_en) begin
        gate_hi_r <= 3'h0;
        gate_lo_r <= 3'h0;
      end else if (state_nxt == MLPS_ST_LOCK) begin
        gate_hi_r <= 3'h0;
        gate_lo_r <= 3'h7;
      end else begin
        gate_hi_r <= drive_hi;
        gate_lo_r <= drive_lo & ~drive_hi;
      end
    end
  end

  assign gate_hi = gate_hi_r;
  assign gate_lo = gate_lo_r;
  assign lock_active = lock_active_r;

  assign status_w = {24'h000000, cause_r, 1'b0, speed_low, therm_off_r, locked};

endmodule
`default_nettype wire

/* File: sim/mlps_hall_model.sv */
`timescale 1ns/10ps
`default_nettype none
// hall comparator of a spinning rotor; holds its level when the rotor stalls
module mlps_hall_model #(
  parameter int HALF = 100
) (
  // clock and stall control
  input wire logic hclk,
  input wire logic run,
  // comparator output
  output logic hall_diff_input
);
  int cnt = 0;
  logic lvl_r = 1'b1;
  always @(posedge hclk) begin
    if (run) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
        lvl_r <= ~lvl_r;
      end
    end
  end
  assign hall_diff_input = lvl_r;
endmodule
`default_nettype wire

/* File: sim/mlps_top_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module mlps_top_asserts #(
  parameter int unsigned TICK_CYCLES = 20000
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins
  input wire logic hall_diff_input,
  input wire logic restart_disable_pin,
  input wire logic standby_request,
  input wire logic supply_low_lockout,
  input wire logic speed_mode_pwm,
  input wire logic speed_below_linear,
  input wire logic direction_select,
  input wire logic brake_request,
  input wire logic temp_above_trip,
  // bridge
  input wire logic [2:0] gate_hi,
  input wire logic [2:0] gate_lo,
  input wire logic lock_active
);
  localparam int unsigned LOCK_CYC = 500 * TICK_CYCLES;
  localparam int unsigned RETRY_CYC = 5000 * TICK_CYCLES;
  int unsigned hall_cnt_r;
  int unsigned lock_cnt_r;
  wire soft_ok = lock_active && !restart_disable_pin;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////
  // cycles since the last hall fall and since soft_ok (lock with restart enabled) last rose
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hall_cnt_r <= 0;
      lock_cnt_r <= 0;
    end else begin
      hall_cnt_r <= $fell(hall_diff_input) ? 0 : hall_cnt_r + 1;
      lock_cnt_r <= soft_ok ? lock_cnt_r + 1 : 0;
    end
  end
  ////////////////////////////////////////////////////////////////
  sequence s_fall;
    $fell(hall_diff_input);
  endsequence
  sequence s_release;
    ##[1:4] !lock_active;
  endsequence
  property p_short_brake;
    lock_active |-> gate_hi == 3'h0 && (gate_lo == 3'h7 || gate_lo == 3'h0);
  endproperty
  a_short_brake: assert property (p_short_brake) else $error("gates wrong in lock");
  property p_force_release;
    lock_active && (standby_request || supply_low_lockout) |-> s_release;
  endproperty
  a_force_release: assert property (p_force_release) else $error("no forced release");
  property p_rds_hold;
    lock_active && restart_disable_pin && !standby_request && !supply_low_lockout |=> lock_active;
  endproperty
  a_rds_hold: assert property (p_rds_hold) else $error("soft release not blocked");
  property p_hall_release;
    (soft_ok ##0 s_fall) |-> s_release;
  endproperty
  a_hall_release: assert property (p_hall_release) else $error("hall fall kept lock");
  property p_speed_release;
    soft_ok && !speed_mode_pwm && speed_below_linear |-> s_release;
  endproperty
  a_speed_release: assert property (p_speed_release) else $error("low speed kept lock");
  property p_dir_release;
    soft_ok && $changed(direction_select) |-> s_release;
  endproperty
  a_dir_release: assert property (p_dir_release) else $error("direction kept lock");
  property p_brake_release;
    soft_ok && brake_request |-> s_release;
  endproperty
  a_brake_release: assert property (p_brake_release) else $error("brake kept lock");
  property p_thermal_off;
    temp_above_trip |-> ##[1:3] (gate_hi == 3'h0 && gate_lo == 3'h0);
  endproperty
  a_thermal_off: assert property (p_thermal_off) else $error("gates on when hot");
  property p_lock_time;
    $rose(lock_active) |-> hall_cnt_r + TICK_CYCLES + 2 >= LOCK_CYC;
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock too early");
  property p_retry_time;
    lock_cnt_r <= RETRY_CYC + 4;
  endproperty
  a_retry_time: assert property (p_retry_time) else $error("retry too late");
endmodule
bind mlps_top mlps_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.hclk, .hresetn,
  .hall_diff_input, .restart_disable_pin, .standby_request, .supply_low_lockout,
  .speed_mode_pwm, .speed_below_linear, .direction_select, .brake_request,
  .temp_above_trip, .gate_hi, .gate_lo, .lock_active);
`default_nettype wire

/* File: sim/motor_lock_protection_supervisor_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module motor_lock_protection_supervisor_tb
  import mlps_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic hwrite = 1'b0;
  logic restart_disable_pin = 1'b0, standby_request = 1'b0, supply_low_lockout = 1'b0;
  logic speed_mode_pwm = 1'b1, speed_command_input = 1'b0, speed_below_linear = 1'b0;
  logic direction_select = 1'b0, brake_request = 1'b0, hrun = 1'b1;
  logic temp_above_trip = 1'b0, temp_below_release = 1'b1;
  // lower drive overlaps the upper one so the same-phase mask is exercised
  logic [2:0] drive_hi = 3'h5, drive_lo = 3'h7;
  logic hreadyout, hresp, hall_diff_input, lock_active;
  logic [31:0] hrdata, r;
  logic [2:0] gate_hi, gate_lo;
  int n_mismatch = 0, n_tests = 0, cyc = 0, pwm_cnt = 0, pwm_high = 60, n;
  mlps_cause_t exp_cause [7] = '{MLPS_CAUSE_STANDBY, MLPS_CAUSE_SUPPLY_LOW_LOCKOUT, MLPS_CAUSE_HALL,
    MLPS_CAUSE_SPEED, MLPS_CAUSE_SPEED, MLPS_CAUSE_DIR, MLPS_CAUSE_BRAKE};
  // tick shortened to 2 cycles: lock after 1000, retry after 10000
  mlps_top #(.TICK_CYCLES(2)) dut_u (.hclk, .hresetn, .hsel(1'b1), .haddr, .htrans,
    .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .hall_diff_input, .restart_disable_pin, .standby_request, .supply_low_lockout,
    .speed_mode_pwm, .speed_command_input, .speed_below_linear, .direction_select,
    .brake_request, .temp_above_trip, .temp_below_release, .drive_hi,
    .drive_lo, .gate_hi, .gate_lo, .lock_active);
  mlps_hall_model #(.HALF(100)) hall_u (.hclk, .run(hrun), .hall_diff_input);
  ////////////////////////////////////////////////////////////////
  initial begin
    forever #25 hclk = ~hclk;
  end
  // speed command pwm, 100 cycle period
  always @(posedge hclk) begin
    pwm_cnt <= (pwm_cnt == 99) ? 0 : pwm_cnt + 1;
    speed_command_input <= (pwm_cnt < pwm_high);
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_mismatch++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  task test_done();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // single word transfer; waits on hready in both phases
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task chk_cause(input mlps_cause_t e);
    bus(1'b0, 8'h04, 32'h0);
    chk({28'h0, r[7:4]}, {28'h0, e});
  endtask
  // spin briefly, then stall the rotor and wait for the lock
  task do_lock();
    hrun <= 1'b1;
    repeat (250) @(posedge hclk);
    hrun <= 1'b0;
    n = 0;
    while (lock_active !== 1'b1 && n < 1300) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task wait_rel(input int lim);
    n = 0;
    while (lock_active === 1'b1 && n < lim) begin
      @(posedge hclk);
      n++;
    end
  endtask
  task calm();
    standby_request <= 1'b0;
    supply_low_lockout <= 1'b0;
    restart_disable_pin <= 1'b0;
    pwm_high <= 60;
    speed_mode_pwm <= 1'b1;
    speed_below_linear <= 1'b0;
    brake_request <= 1'b0;
    hrun <= 1'b1;
    repeat (2) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (3) @(posedge hclk);
    chk({26'h0, gate_hi, gate_lo}, 32'h2A);
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'h3);
    chk({31'h0, hresp}, 32'h0);
    bus(1'b1, 8'h00, 32'h1);
    bus(1'b0, 8'h00, 32'h0);
    chk(r, 32'h1);
    bus(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h0);
    // drive disabled: every gate off whatever the waveform asks
    bus(1'b1, 8'h00, 32'h2);
    repeat (2) @(posedge hclk);
    chk({26'h0, gate_hi, gate_lo}, 32'h0);
    bus(1'b1, 8'h00, 32'h3);
    do_lock();
    chk(n >= 790 && n <= 1012, 32'h1);
    chk({26'h0, gate_hi, gate_lo}, 32'h07);
    for (int k = 0; k < 7; k++) begin
      do_lock();
      case (k)
        0: standby_request <= 1'b1;
        1: supply_low_lockout <= 1'b1;
        2: hrun <= 1'b1;
        3: pwm_high <= 2;
        4: begin
          speed_mode_pwm <= 1'b0;
          speed_below_linear <= 1'b1;
        end
        5: direction_select <= ~direction_select;
        default: brake_request <= 1'b1;
      endcase
      wait_rel(300);
      chk(lock_active, 32'h0);
      calm();
      chk_cause(exp_cause[k]);
    end
    do_lock();
    wait_rel(10100);
    chk(n >= 9994 && n <= 10006, 32'h1);
    chk_cause(MLPS_CAUSE_RETRY);
    restart_disable_pin <= 1'b1;
    do_lock();
    brake_request <= 1'b1;
    direction_select <= ~direction_select;
    speed_mode_pwm <= 1'b0;
    speed_below_linear <= 1'b1;
    hrun <= 1'b1;
    wait_rel(10100);
    chk(lock_active, 32'h1);
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 32'h00000035);
    bus(1'b0, 8'h08, 32'h0);
    chk(r, 32'h00001388);
    standby_request <= 1'b1;
    wait_rel(5);
    chk(lock_active, 32'h0);
    calm();
    chk_cause(MLPS_CAUSE_STANDBY);
    bus(1'b0, 8'h08, 32'h0);
    chk(r, 32'h0);
    temp_above_trip <= 1'b1;
    temp_below_release <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({26'h0, gate_hi, gate_lo}, 32'h0);
    temp_above_trip <= 1'b0;
    repeat (4) @(posedge hclk);
    chk({26'h0, gate_hi, gate_lo}, 32'h0);
    bus(1'b0, 8'h04, 32'h0);
    chk(r, 32'h00000012);
    temp_below_release <= 1'b1;
    drive_hi <= 3'h2;
    drive_lo <= 3'h5;
    repeat (4) @(posedge hclk);
    chk({26'h0, gate_hi, gate_lo}, 32'h15);
    test_done();
  end
endmodule
`default_nettype wire
